// file: dmas_pkg.sv
// Constants and types for the differential mux and converter sequencer.
// How it works
// - With the strobe high, muxes take one bit per rising serial clock at 5MHz.
// - Strobe falls after shifting, latching the pair onto the converter inputs.
// - The converter samples and starts converting on conversion start falling.
// - Up to 625ksps changing pairs, 1.25Msps when the pair repeats.
// - Converter output drivers follow the read strobe from the sequencer.
// - Converter result is valid 20ns before busy rises.
package dmas_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SCLK_PERIOD_NS = 200;
  localparam int unsigned SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned SETTLE_NS = 700;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_SETUP_NS = 20;
  localparam int unsigned SEL_BITS = 4;
  localparam logic [0:0] SEL_ENABLE = 1'h1;
  localparam int unsigned PAIR_BITS = 3;
  localparam int unsigned DATA_BITS = 12;
  localparam int unsigned CONV_PULSE_CYC = 2;
  localparam int unsigned READ_CYC = 3;
  localparam logic [2:0] PAIR_RESET = 3'h0;

  typedef struct packed {
    logic [PAIR_BITS-1:0] pair;
    logic [DATA_BITS-1:0] data;
  } dmas_sample_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_SETTLE = 2'b10,
    S_DRAIN = 2'b11
  } dmas_state_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_CONV = 2'b01,
    L_WAIT = 2'b10,
    L_READ = 2'b11
  } dmas_link_state_t;
endpackage : dmas_pkg

// file: dmas_sequencer.sv
// Sequencer that loads mux pairs serially and runs the converter.
module dmas_sequencer #(
  parameter int unsigned LEN_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic seq_start,
  input wire logic [LEN_W-1:0] seq_len,
  input wire logic scan_all,
  input wire logic [dmas_pkg::PAIR_BITS-1:0] fixed_pair,
  output logic seq_active,
  output logic mux_select_strobe,
  output logic mux_sdata,
  output logic mux_sclk,
  output logic adc_cs_n,
  output logic conversion_start_n,
  output logic adc_rd_n,
  input wire logic adc_busy,
  input wire logic [dmas_pkg::DATA_BITS-1:0] adc_data,
  output logic out_valid,
  input wire logic out_ready,
  output dmas_pkg::dmas_sample_t out_sample
);
  ////////////////////////////////////////////////////////////////////////////
  // System domain state.
  dmas_pkg::dmas_state_t state_q;
  logic [LEN_W-1:0] remain_q;
  logic [dmas_pkg::PAIR_BITS-1:0] pair_q;
  logic [dmas_pkg::PAIR_BITS-1:0] conv_pair_q;
  logic [dmas_pkg::SEL_BITS-1:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] div_q;
  logic [7:0] settle_q;
  logic start_tgl_q;
  logic conv_pend_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic done_evt;
  logic settled;
  logic can_start;
  logic fire;
  logic last_conv;
  logic [dmas_pkg::PAIR_BITS-1:0] next_pair;
  logic buf_in_ready;
  dmas_pkg::dmas_sample_t link_result_q;
  logic link_done_tgl_q;

  assign done_evt = done_s2_q ^ done_s3_q;
  assign settled = (settle_q == 8'(dmas_pkg::SETTLE_CYC));
  assign can_start = !conv_pend_q && buf_in_ready;
  assign fire = (state_q == dmas_pkg::S_SETTLE) && settled && can_start;
  assign last_conv = (remain_q == LEN_W'(1));
  assign next_pair = scan_all ? pair_q + 3'h1 : fixed_pair;
  assign seq_active = (state_q != dmas_pkg::S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Result toggle crossing from the link domain.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_s1_q <= 1'h0;
      done_s2_q <= 1'h0;
      done_s3_q <= 1'h0;
    end else begin
      done_s1_q <= link_done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state machine and serial pair loading.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= dmas_pkg::S_IDLE;
      remain_q <= '0;
      pair_q <= dmas_pkg::PAIR_RESET;
      shift_q <= '0;
      bit_cnt_q <= 3'h0;
      div_q <= 8'h00;
      mux_select_strobe <= 1'h0;
      mux_sdata <= 1'h0;
      mux_sclk <= 1'h0;
    end else begin
      unique case (state_q)
        dmas_pkg::S_IDLE: begin
          if (seq_start && seq_len != '0) begin
            remain_q <= seq_len;
            // Scan always begins at pair zero.
            pair_q <= scan_all ? dmas_pkg::PAIR_RESET : fixed_pair;
            shift_q <= {dmas_pkg::SEL_ENABLE,
                        scan_all ? dmas_pkg::PAIR_RESET : fixed_pair};
            bit_cnt_q <= 3'h0;
            div_q <= 8'h00;
            mux_select_strobe <= 1'h1;
            state_q <= dmas_pkg::S_LOAD;
          end
        end
        dmas_pkg::S_LOAD: begin
          mux_sdata <= shift_q[dmas_pkg::SEL_BITS-1];
          if (div_q == 8'(dmas_pkg::SCLK_HALF_CYC - 1)) begin
            div_q <= 8'h00;
            mux_sclk <= !mux_sclk;
            if (mux_sclk) begin
              shift_q <= {shift_q[dmas_pkg::SEL_BITS-2:0], 1'h0};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'(dmas_pkg::SEL_BITS - 1)) begin
                mux_select_strobe <= 1'h0;
                state_q <= dmas_pkg::S_SETTLE;
              end
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        dmas_pkg::S_SETTLE: begin
          if (fire) begin
            remain_q <= remain_q - LEN_W'(1);
            if (last_conv) begin
              state_q <= dmas_pkg::S_DRAIN;
            end else if (next_pair == pair_q) begin
              // A repeated pair skips the reload and waits for the converter.
              state_q <= dmas_pkg::S_SETTLE;
            end else begin
              pair_q <= next_pair;
              shift_q <= {dmas_pkg::SEL_ENABLE, next_pair};
              bit_cnt_q <= 3'h0;
              div_q <= 8'h00;
              mux_select_strobe <= 1'h1;
              state_q <= dmas_pkg::S_LOAD;
            end
          end
        end
        dmas_pkg::S_DRAIN: begin
          if (!conv_pend_q) begin
            state_q <= dmas_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling time after the strobe falls, cleared while a frame loads.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      settle_q <= 8'h00;
    end else if (state_q == dmas_pkg::S_LOAD) begin
      // The wait restarts with every frame so each pair gets its full time.
      settle_q <= 8'h00;
    end else if (state_q == dmas_pkg::S_SETTLE && !settled) begin
      settle_q <= settle_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion start toggle and the pending flag.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_tgl_q <= 1'h0;
      conv_pend_q <= 1'h0;
      conv_pair_q <= dmas_pkg::PAIR_RESET;
    end else begin
      // Fire waits for the previous result, so start and done never meet.
      if (fire) begin
        start_tgl_q <= !start_tgl_q;
        conv_pend_q <= 1'h1;
        conv_pair_q <= pair_q;
      end else if (done_evt) begin
        conv_pend_q <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter chip select, low for the whole series.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adc_cs_n <= 1'h1;
    end else begin
      adc_cs_n <= !(seq_active || (seq_start && seq_len != '0));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer between the converter and the user.
  dmas_pkg::dmas_sample_t buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_push;
  logic buf_pop;

  assign buf_in_ready = (buf_cnt_q != 2'h2);
  assign buf_push = done_evt;
  assign buf_pop = out_valid && out_ready;
  assign out_valid = (buf_cnt_q != 2'h0);
  assign out_sample = buf_q[0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      buf_cnt_q <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (buf_pop) begin
        buf_q[0] <= buf_q[1];
      end
      // The link word is steady here: it changed before its toggle crossed.
      if (buf_push) begin
        if (buf_cnt_q == 2'h0 || (buf_cnt_q == 2'h1 && buf_pop)) begin
          buf_q[0] <= '{pair: conv_pair_q, data: link_result_q.data};
        end else begin
          buf_q[1] <= '{pair: conv_pair_q, data: link_result_q.data};
        end
      end
      buf_cnt_q <= buf_cnt_q + 2'(buf_push) - 2'(buf_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: conversion start, end of conversion and read.
  dmas_pkg::dmas_link_state_t lstate_q;
  logic st_s1_q;
  logic st_s2_q;
  logic st_s3_q;
  logic bz_s1_q;
  logic bz_s2_q;
  logic bz_s3_q;
  logic [dmas_pkg::DATA_BITS-1:0] dt_s1_q;
  logic [dmas_pkg::DATA_BITS-1:0] dt_s2_q;
  logic [2:0] lcnt_q;

  // Busy and data are pins and pass two flip-flops before use.
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      st_s1_q <= 1'h0;
      st_s2_q <= 1'h0;
      st_s3_q <= 1'h0;
      bz_s1_q <= 1'h1;
      bz_s2_q <= 1'h1;
      bz_s3_q <= 1'h1;
      dt_s1_q <= '0;
      dt_s2_q <= '0;
    end else begin
      st_s1_q <= start_tgl_q;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      bz_s1_q <= adc_busy;
      bz_s2_q <= bz_s1_q;
      bz_s3_q <= bz_s2_q;
      dt_s1_q <= adc_data;
      dt_s2_q <= dt_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine: start pulse, wait for busy, read strobe.
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lstate_q <= dmas_pkg::L_IDLE;
      lcnt_q <= 3'h0;
      conversion_start_n <= 1'h1;
      adc_rd_n <= 1'h1;
      link_result_q <= '0;
      link_done_tgl_q <= 1'h0;
    end else begin
      unique case (lstate_q)
        dmas_pkg::L_IDLE: begin
          if (st_s2_q ^ st_s3_q) begin
            conversion_start_n <= 1'h0;
            lcnt_q <= 3'h0;
            lstate_q <= dmas_pkg::L_CONV;
          end
        end
        dmas_pkg::L_CONV: begin
          lcnt_q <= lcnt_q + 3'h1;
          if (lcnt_q == 3'(dmas_pkg::CONV_PULSE_CYC - 1)) begin
            conversion_start_n <= 1'h1;
            lstate_q <= dmas_pkg::L_WAIT;
          end
        end
        dmas_pkg::L_WAIT: begin
          if (bz_s2_q && !bz_s3_q) begin
            adc_rd_n <= 1'h0;
            lcnt_q <= 3'h0;
            lstate_q <= dmas_pkg::L_READ;
          end
        end
        dmas_pkg::L_READ: begin
          lcnt_q <= lcnt_q + 3'h1;
          if (lcnt_q == 3'(dmas_pkg::READ_CYC - 1)) begin
            // Data is taken at the end of the read strobe.
            link_result_q.data <= dt_s2_q;
            adc_rd_n <= 1'h1;
            link_done_tgl_q <= !link_done_tgl_q;
            lstate_q <= dmas_pkg::L_IDLE;
          end
        end
      endcase
    end
  end
endmodule : dmas_sequencer

// file: dmas_sequencer_asserts.sv
// Checker for the sequencer's serial load, conversion and output ports.
module dmas_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic seq_active,
  input wire logic mux_select_strobe,
  input wire logic mux_sdata,
  input wire logic mux_sclk,
  input wire logic adc_cs_n,
  input wire logic conversion_start_n,
  input wire logic adc_rd_n,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire dmas_pkg::dmas_sample_t out_sample
);
  logic [7:0] low_q;
  logic strobe_q;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Counts the cycles since the strobe last fell.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'h0;
      low_q <= 8'h00;
    end else begin
      strobe_q <= mux_select_strobe;
      if (strobe_q && !mux_select_strobe) begin
        low_q <= 8'h01;
      end else if (low_q != 8'hFF) begin
        low_q <= low_q + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_sclk_in_frame: assert property (mux_sclk |-> mux_select_strobe)
    else $error("serial clock outside frame");
  a_data_steady: assert property (mux_sclk |-> $stable(mux_sdata))
    else $error("serial data moved while clock high");
  a_sclk_high_time: assert property
    ($rose(mux_sclk) |-> ##25 $fell(mux_sclk))
    else $error("serial clock high time wrong");
  a_sclk_low_time: assert property
    ($fell(mux_sclk) && mux_select_strobe |-> ##25 $rose(mux_sclk))
    else $error("serial clock low time wrong");
  a_frame_length: assert property
    ($rose(mux_select_strobe) |-> ##200 $fell(mux_select_strobe))
    else $error("strobe frame length wrong");
  a_frame_end_edge: assert property
    ($fell(mux_select_strobe) |-> $fell(mux_sclk))
    else $error("strobe fell off a clock falling edge");
  a_settle_time: assert property
    ($fell(conversion_start_n) |-> low_q >= 8'hAE)
    else $error("conversion started too soon after strobe");
  a_cs_covers_conv: assert property
    (!conversion_start_n || !adc_rd_n |-> !adc_cs_n)
    else $error("converter not selected");
  a_read_apart: assert property (!adc_rd_n |-> conversion_start_n)
    else $error("read overlaps conversion start");
  a_idle_quiet: assert property
    (!seq_active && !$past(seq_active) |-> !mux_select_strobe)
    else $error("strobe active while idle");
  a_hold_sample: assert property
    (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("sample dropped while stalled");
  c_conv: cover property ($fell(conversion_start_n));
  c_stall: cover property (out_valid && !out_ready);
  c_done: cover property ($fell(seq_active));
endmodule : dmas_chk

bind dmas_sequencer dmas_chk chk_u (.sys_clk, .rstn, .seq_active,
  .mux_select_strobe, .mux_sdata, .mux_sclk, .adc_cs_n,
  .conversion_start_n, .adc_rd_n, .out_valid, .out_ready, .out_sample);

// file: dmas_front_model.sv
// Behavioural model of the two muxes and the sampling converter.
module dmas_front_model #(
  parameter int CONV_NS = 600
) (
  input wire logic mux_select_strobe,
  input wire logic mux_sdata,
  input wire logic mux_sclk,
  input wire logic adc_cs_n,
  input wire logic conversion_start_n,
  input wire logic adc_rd_n,
  output logic adc_busy,
  output logic [11:0] adc_data,
  output int loads,
  output int faults
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] shift_q = 4'h0;
  logic [2:0] pair_q = 3'h0;
  logic [11:0] result_q = 12'h000;
  logic [8:0] seq_q = 9'h000;
  realtime fall_t = 0.0;
  initial begin
    adc_busy = 1'b1;
    loads = 0;
    faults = 0;
  end
  always @(posedge mux_sclk) begin
    if (mux_select_strobe) shift_q <= {shift_q[2:0], mux_sdata};
  end
  always @(negedge mux_select_strobe) begin
    pair_q = shift_q[2:0];
    fall_t = $realtime;
    loads++;
    if (shift_q[3] !== 1'b1) faults++;
  end
  always @(negedge conversion_start_n) begin : conv
    logic [2:0] cur;
    cur = pair_q;
    if ($realtime - fall_t < 700.0 || adc_cs_n !== 1'b0 || !adc_busy) faults++;
    adc_busy = 1'b0;
    #(CONV_NS - 20) result_q = {cur, seq_q};
    seq_q++;
    #20 adc_busy = 1'b1;
  end
  // Released outputs show the inverse of the result, never a held copy.
  assign adc_data = adc_rd_n ? ~result_q : result_q;
endmodule : dmas_front_model

// file: dmas_sequencer_tb_top.sv
// Self-checking bench for the sequencer with its front-end model.
module dmas_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic seq_start = 1'b0;
  logic [7:0] seq_len = 8'h00;
  logic scan_all = 1'b0;
  logic [2:0] fixed_pair = 3'h0;
  logic out_ready = 1'b0;
  logic seq_active, mux_select_strobe, mux_sdata, mux_sclk, adc_cs_n;
  logic conversion_start_n, adc_rd_n, adc_busy, out_valid;
  logic [11:0] adc_data;
  logic [8:0] conv_n = 9'h000;
  dmas_pkg::dmas_sample_t out_sample;
  int loads, faults, l0;
  int failures = 0;
  int n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  always #24 link_clk = ~link_clk;
  dmas_sequencer #(.LEN_W(8)) dut_u (.sys_clk, .rstn, .link_clk, .seq_start,
    .seq_len, .scan_all, .fixed_pair, .seq_active, .mux_select_strobe,
    .mux_sdata, .mux_sclk, .adc_cs_n, .conversion_start_n, .adc_rd_n,
    .adc_busy, .adc_data, .out_valid, .out_ready, .out_sample);
  dmas_front_model model_u (.mux_select_strobe, .mux_sdata, .mux_sclk,
    .adc_cs_n, .conversion_start_n, .adc_rd_n, .adc_busy, .adc_data, .loads,
    .faults);
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %0h want %0h", $time, seen, want);
    end
  endtask : check
  task automatic start(input logic [7:0] len, input logic scan,
                       input logic [2:0] pair);
    seq_len = len;
    scan_all = scan;
    fixed_pair = pair;
    seq_start = 1'b1;
    tick();
    seq_start = 1'b0;
  endtask : start
  task automatic drain(input int len, input logic scan, input logic [2:0] pair,
                       input int stall);
    int n;
    logic [2:0] e;
    for (int i = 0; i < len; i++) begin
      n = 0;
      e = scan ? 3'(i % 8) : pair;
      repeat (stall) tick();
      while (out_valid !== 1'b1) begin
        tick();
        n++;
        if (n > 9000) begin
          failures++;
          give_verdict();
        end
      end
      check(32'(out_sample.pair), 32'(e));
      check(32'(out_sample.data), 32'({e, conv_n}));
      out_ready = 1'b1;
      tick();
      out_ready = 1'b0;
      tick();
      conv_n++;
    end
    repeat (20) tick();
    check(32'(seq_active), 32'h0);
    check(32'(adc_cs_n), 32'h1);
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_zero_len();
    start(8'h00, 1'b0, 3'h2);
    repeat (5) tick();
    check(32'(seq_active), 32'h0);
    check(32'(mux_select_strobe), 32'h0);
  endtask : sc_zero_len
  task automatic sc_scan_wrap();
    l0 = loads;
    start(8'h0A, 1'b1, 3'h0);
    drain(10, 1'b1, 3'h0, 0);
    check(loads - l0, 32'hA);
  endtask : sc_scan_wrap
  task automatic sc_same_pair();
    l0 = loads;
    start(8'h03, 1'b0, 3'h5);
    drain(3, 1'b0, 3'h5, 0);
    check(loads - l0, 32'h1);
  endtask : sc_same_pair
  task automatic sc_stall_refuse();
    start(8'h04, 1'b1, 3'h0);
    tick();
    seq_len = 8'h01;
    seq_start = 1'b1;
    tick();
    seq_start = 1'b0;
    drain(4, 1'b1, 3'h0, 3000);
  endtask : sc_stall_refuse
  initial begin
    repeat (3) @(posedge link_clk);
    tick();
    rstn = 1'b1;
    sc_zero_len();
    sc_scan_wrap();
    sc_same_pair();
    sc_stall_refuse();
    check(faults, 32'h0);
    give_verdict();
  end
endmodule : dmas_sequencer_tb_top
